// *** sync_dual_port_ram_port.sv ***
// Purpose: one port of a synchronous dual-port ram, 8k x 18
// Assumes: port inputs come from logic on i_clock; output enable is asynchronous
// Notes: o_data_oe is gated by the output enable without a clock
module sync_dual_port_ram_port (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_clock_enable,
   input wire logic i_select_active_low,
   input wire logic i_select_active_high,
   input wire logic i_read_write,
   input wire logic i_output_enable_n,
   input wire logic i_output_register_select,
   input wire logic i_upper_byte_select_n,
   input wire logic i_lower_byte_select_n,
   input wire logic i_address_strobe_n,
   input wire logic i_count_advance_n,
   input wire logic i_counter_clear_n,
   input wire logic [sdp_port_pkg::ADDR_W-1:0] i_address,
   input wire logic [sdp_port_pkg::DATA_W-1:0] i_data,
   output logic [sdp_port_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe
);
   logic rst_meta_r;
   logic rst_n;
   logic [sdp_port_pkg::ADDR_W-1:0] access_addr;
   logic selected;
   logic do_read;
   logic do_write;
   logic [sdp_port_pkg::DATA_W-1:0] mem [0:sdp_port_pkg::DEPTH-1];
   logic [sdp_port_pkg::DATA_W-1:0] fdata_r;
   logic [sdp_port_pkg::DATA_W-1:0] fdata_nxt;
   logic [sdp_port_pkg::DATA_W-1:0] out_r;
   logic [sdp_port_pkg::DATA_W-1:0] out_nxt;
   logic drive1_r;
   logic drive1_nxt;
   logic drive_r;
   logic drive_nxt;

   // reset release is synchronised; assertion is immediate
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   burst_address_counter u_counter (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_enable(i_clock_enable),
      .i_counter_clear_n(i_counter_clear_n),
      .i_address_strobe_n(i_address_strobe_n),
      .i_count_advance_n(i_count_advance_n),
      .i_address(i_address),
      .o_access_address(access_addr)
   );

   always_comb begin
      selected = !i_select_active_low && i_select_active_high;
      do_read = selected && i_read_write;
      do_write = selected && !i_read_write;
      fdata_nxt = mem[access_addr];
      drive1_nxt = do_read;
      // pipelined path takes the word fetched one edge earlier
      out_nxt = i_output_register_select ? fdata_r : fdata_nxt;
      drive_nxt = i_output_register_select ? drive1_r : do_read;
   end

   // output stage is sampled only on the rising edge
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         fdata_r <= sdp_port_pkg::DATA_RESET;
         out_r <= sdp_port_pkg::DATA_RESET;
         drive1_r <= 1'b0;
         drive_r <= 1'b0;
      end else if (i_clock_enable) begin
         fdata_r <= fdata_nxt;
         out_r <= out_nxt;
         drive1_r <= drive1_nxt;
         drive_r <= drive_nxt;
      end
   end

   // array has no reset; a word written during reset is dropped
   always_ff @(posedge i_clock) begin
      if (rst_n && i_clock_enable && do_write) begin
         if (!i_lower_byte_select_n) begin
            mem[access_addr][sdp_port_pkg::LOW_LANE_MSB:0] <= i_data[sdp_port_pkg::LOW_LANE_MSB:0];
         end
         if (!i_upper_byte_select_n) begin
            mem[access_addr][sdp_port_pkg::DATA_W-1:sdp_port_pkg::HIGH_LANE_LSB] <=
               i_data[sdp_port_pkg::DATA_W-1:sdp_port_pkg::HIGH_LANE_LSB];
         end
      end
   end

   assign o_data = out_r;
   // only unclocked term of the port: output enable must float the pins at once
   assign o_data_oe = drive_r && !i_output_enable_n;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!rst_n);

   a_oe_floats: assert property (i_output_enable_n |-> !o_data_oe)
      else $error("data driven while output enable high");
   a_flow_path: assert property ((i_clock_enable && !i_output_register_select) |=> o_data == fdata_r)
      else $error("flow-through data not from current word");
   a_pipe_lag: assert property ((i_clock_enable && i_output_register_select) |=> o_data == $past(fdata_r))
      else $error("pipelined data not one cycle late");
   a_flow_deselect: assert property ((i_clock_enable && !i_output_register_select && !selected)
      |=> !o_data_oe)
      else $error("deselected flow-through port still drives");
   a_pipe_deselect: assert property ((i_clock_enable && i_output_register_select && !selected)
      ##1 (i_clock_enable && i_output_register_select) |=> !o_data_oe)
      else $error("pipelined deselect not one cycle late");
   a_pipe_read_drive: assert property ((i_clock_enable && i_output_register_select && do_read)
      ##1 (i_clock_enable && i_output_register_select) |=> drive_r)
      else $error("pipelined read did not drive from previous controls");
   a_read_drives: assert property ((i_clock_enable && !i_output_register_select && do_read) |=> drive_r)
      else $error("flow-through read did not drive");
   a_write_lands: assert property ((i_clock_enable && do_write && !i_lower_byte_select_n
      && !i_upper_byte_select_n) |=> mem[$past(access_addr)] == $past(i_data))
      else $error("written word not stored");
   a_lane_kept: assert property ((i_clock_enable && do_write && i_lower_byte_select_n
      && i_upper_byte_select_n) |=> mem[$past(access_addr)] == $past(fdata_nxt))
      else $error("unselected lanes changed");
   a_count_unselected: assert property ((i_counter_clear_n && !i_address_strobe_n && !selected)
      |-> access_addr == i_address)
      else $error("counter load depends on select");
   a_clear_access: assert property ((i_clock_enable && !i_counter_clear_n && do_read
      && !i_output_register_select) |=> o_data == $past(mem[0]))
      else $error("read with counter clear missed word zero");

   c_write: cover property (i_clock_enable && do_write);
   c_flow_read: cover property (i_clock_enable && do_read && !i_output_register_select);
   c_pipe_read: cover property ((i_clock_enable && do_read && i_output_register_select) ##1 o_data_oe);
   c_clear_read: cover property (i_clock_enable && do_read && !i_counter_clear_n);
endmodule // sync_dual_port_ram_port

// *** sdp_port_pkg.sv ***
// Purpose: shared constants for one port of a synchronous dual-port ram
// Assumes: 8k words of 18 bits, one clock per port
// Notes: widths are fixed, not parameters
package sdp_port_pkg;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 13;
   localparam int DEPTH = 8192;
   localparam int LOW_LANE_MSB = 8;
   localparam int HIGH_LANE_LSB = 9;
   localparam logic [12:0] CLEAR_ADDR = 13'h0000;
   localparam logic [12:0] STEP = 13'h0001;
   localparam logic [12:0] TOP_ADDR = 13'h1fff;
   localparam logic [17:0] DATA_RESET = 18'h00000;

   typedef enum logic [1:0] {
      MODE_CLEAR = 2'b00,
      MODE_LOAD = 2'b01,
      MODE_HOLD = 2'b10,
      MODE_STEP = 2'b11
   } count_mode_t;
endpackage

// *** burst_address_counter.sv ***
// Purpose: burst address counter with clear, load, hold and step
// Assumes: controls come from logic on the same clock
// Notes: o_access_address is the address used at the current edge
module burst_address_counter (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_counter_clear_n,
   input wire logic i_address_strobe_n,
   input wire logic i_count_advance_n,
   input wire logic [sdp_port_pkg::ADDR_W-1:0] i_address,
   output logic [sdp_port_pkg::ADDR_W-1:0] o_access_address
);
   sdp_port_pkg::count_mode_t mode;
   logic [sdp_port_pkg::ADDR_W-1:0] count_r;
   logic [sdp_port_pkg::ADDR_W-1:0] count_nxt;

   always_comb begin
      if (!i_counter_clear_n) begin
         mode = sdp_port_pkg::MODE_CLEAR;
      end else if (!i_address_strobe_n) begin
         mode = sdp_port_pkg::MODE_LOAD;
      end else if (i_count_advance_n) begin
         mode = sdp_port_pkg::MODE_HOLD;
      end else begin
         mode = sdp_port_pkg::MODE_STEP;
      end
      unique case (mode)
         sdp_port_pkg::MODE_CLEAR: count_nxt = sdp_port_pkg::CLEAR_ADDR;
         sdp_port_pkg::MODE_LOAD: count_nxt = i_address;
         sdp_port_pkg::MODE_HOLD: count_nxt = count_r;
         sdp_port_pkg::MODE_STEP: count_nxt = count_r + sdp_port_pkg::STEP;
      endcase
      o_access_address = count_nxt;
   end

   // no chip select input here: counting runs whether or not the port is selected
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_r <= sdp_port_pkg::CLEAR_ADDR;
      end else if (i_enable) begin
         count_r <= count_nxt;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_clear_to_zero: assert property (!i_counter_clear_n |-> o_access_address == 13'h0000)
      else $error("counter clear did not give address zero");
   a_load_external: assert property ((i_counter_clear_n && !i_address_strobe_n) |-> o_access_address == i_address)
      else $error("strobe did not load the external address");
   a_hold_count: assert property ((i_counter_clear_n && i_address_strobe_n && i_count_advance_n)
      |-> o_access_address == count_r)
      else $error("counter did not hold");
   a_step_wrap: assert property ((i_counter_clear_n && i_address_strobe_n && !i_count_advance_n
      && count_r == sdp_port_pkg::TOP_ADDR) |-> o_access_address == 13'h0000)
      else $error("counter did not wrap to zero");
   a_count_kept: assert property (i_enable |=> count_r == $past(o_access_address))
      else $error("counter did not store the accessed address");
   c_step_wrap: cover property (i_counter_clear_n && i_address_strobe_n && !i_count_advance_n
      && count_r == sdp_port_pkg::TOP_ADDR);
endmodule // burst_address_counter

// *** sdp_port_master.sv ***
// Purpose: behavioural bus master for one ram port
// Assumes: every request is launched just after a rising edge
// Notes: requests hold until the next call; single port, so no far-port reads
module sdp_port_master (
   input wire logic i_clock,
   output logic o_select_active_low,
   output logic o_select_active_high,
   output logic o_read_write,
   output logic o_address_strobe_n,
   output logic o_count_advance_n,
   output logic o_counter_clear_n,
   output logic o_upper_byte_select_n,
   output logic o_lower_byte_select_n,
   output logic [sdp_port_pkg::ADDR_W-1:0] o_address,
   output logic [sdp_port_pkg::DATA_W-1:0] o_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {o_select_active_low, o_select_active_high, o_read_write} = 3'b101;
      {o_address_strobe_n, o_count_advance_n, o_counter_clear_n} = 3'b111;
      {o_upper_byte_select_n, o_lower_byte_select_n} = 2'b11;
      o_address = 13'h0000;
      o_data = 18'h00000;
   end
   // c = {select, read, strobe_n, advance_n, clear_n, upper_n, lower_n}
   // no no-operation gap is issued between read and write runs
   // far-port write-to-read spacing never arises with one port
   task automatic cyc(input logic [6:0] c, input logic [12:0] a, input logic [17:0] d);
      @(posedge i_clock);
      o_select_active_low <= ~c[6];
      o_select_active_high <= c[6];
      {o_read_write, o_address_strobe_n, o_count_advance_n, o_counter_clear_n} <= c[5:2];
      {o_upper_byte_select_n, o_lower_byte_select_n} <= c[1:0];
      o_address <= a;
      // data not written is scrambled so stale values cannot pass
      o_data <= c[5] ? ~o_data : d;
   endtask
endmodule // sdp_port_master

// *** sync_dual_port_ram_port_tb_top.sv ***
// Purpose: self-checking bench for one ram port
// Assumes: flow-through first, pipelined last, so modes never mix mid-stream
// Notes: expectations are fixed words, never read from the design
module sync_dual_port_ram_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] IDLE = 7'b0111111;
   localparam logic [6:0] WR = 7'b1000100;
   localparam logic [6:0] WR_STEP = 7'b1010100;
   localparam logic [6:0] RD = 7'b1101111;
   logic clk = 1'b0, rstn = 1'b0, pipe = 1'b0, oe_n = 1'b0, ce = 1'b1;
   logic sl, sh, rw, address_strobe_n, cnt, clr, ub, lb, oe;
   logic [12:0] addr;
   logic [17:0] wdata, rdata;
   int failures = 0, cmp_count = 0;
   initial forever #2 clk = ~clk;
   sdp_port_master i_master (.i_clock(clk), .o_select_active_low(sl), .o_select_active_high(sh),
      .o_read_write(rw), .o_address_strobe_n(address_strobe_n), .o_count_advance_n(cnt), .o_counter_clear_n(clr),
      .o_upper_byte_select_n(ub), .o_lower_byte_select_n(lb), .o_address(addr), .o_data(wdata));
   sync_dual_port_ram_port i_dut (.i_clock(clk), .i_rstn(rstn), .i_clock_enable(ce),
      .i_select_active_low(sl), .i_select_active_high(sh), .i_read_write(rw), .i_output_enable_n(oe_n),
      .i_output_register_select(pipe), .i_upper_byte_select_n(ub), .i_lower_byte_select_n(lb),
      .i_address_strobe_n(address_strobe_n), .i_count_advance_n(cnt), .i_counter_clear_n(clr), .i_address(addr),
      .i_data(wdata), .o_data(rdata), .o_data_oe(oe));
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (failures == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // one read, then deselect; drive must fall one edge after the word shows
   task automatic rd(input logic [6:0] c, input logic [12:0] a, input logic [17:0] exp);
      i_master.cyc(c, a, 18'h00000);
      i_master.cyc(IDLE, 13'h0000, 18'h00000);
      if (pipe) begin
         @(posedge clk);
      end
      #1;
      chk(rdata, exp);
      chk(oe, 1'b1);
      @(posedge clk);
      #1;
      chk(oe, 1'b0);
   endtask
   initial begin
      #2000;
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(oe, 1'b0);
      i_master.cyc(WR, 13'h0007, 18'h3ffff);
      i_master.cyc(7'b1000110, 13'h0007, 18'h00000);
      rd(RD, 13'h0007, 18'h3fe00);
      i_master.cyc(RD, 13'h0007, 18'h00000);
      @(posedge clk);
      oe_n <= 1'b1;
      #1;
      chk(oe, 1'b0);
      @(posedge clk);
      oe_n <= 1'b0;
      #1;
      chk(oe, 1'b1);
      i_master.cyc(WR, 13'h1ffe, 18'h00011);
      i_master.cyc(WR_STEP, 13'h0aaa, 18'h00022);
      i_master.cyc(WR_STEP, 13'h0aaa, 18'h00033);
      rd(RD, 13'h1fff, 18'h00022);
      rd(RD, 13'h0000, 18'h00033);
      i_master.cyc(WR, 13'h0001, 18'h00066);
      i_master.cyc(7'b1000000, 13'h0055, 18'h00044);
      i_master.cyc(7'b0110111, 13'h0aaa, 18'h00000);
      rd(7'b1111111, 13'h0aaa, 18'h00066);
      rd(7'b1100011, 13'h0aaa, 18'h00044);
      @(posedge clk);
      pipe <= 1'b1;
      rd(RD, 13'h0001, 18'h00066);
      // clock enable low must drop the write; a write with no lane selected changes nothing
      @(posedge clk);
      ce <= 1'b0;
      i_master.cyc(WR, 13'h0001, 18'h00000);
      i_master.cyc(IDLE, 13'h0000, 18'h00000);
      @(posedge clk);
      ce <= 1'b1;
      i_master.cyc(7'b1000111, 13'h0001, 18'h00000);
      rd(RD, 13'h0001, 18'h00066);
      report_and_stop();
   end
endmodule // sync_dual_port_ram_port_tb_top
